// ---- common/irq_ctl_defs.vh ----
`ifndef IRQ_CTL_DEFS_VH
`define IRQ_CTL_DEFS_VH

// opcodes handled by this block
`define OPC_USER_IRQ_ENABLE  8'h99
`define OPC_USER_IRQ_DISABLE 8'h98
`define OPC_WAIT_FOR_IRQ     8'h94

// execution length of each handled instruction, in core cycles
`define INSTR_CYCLES         3'h4

// reset value of the user global enable bit
`define USER_IRQ_EN_RESET    1'b0

`endif

// ---- rtl/irq_ack_gate.v ----
`timescale 1ns/10ps
`default_nettype none
module irq_ack_gate
#(
    parameter N_IRQ = 4
)
(
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [N_IRQ-1:0] i_pend,
    input  wire [N_IRQ-1:0] i_mask_n,
    input  wire             i_user_en,
    input  wire             i_master_dis,
    output wire             o_take,
    output reg  [N_IRQ-1:0] o_ack_sel
);
    wire [N_IRQ-1:0] live;

    // unmasked pending requests, gated by both global enables
    assign live   = i_pend & i_mask_n;
    assign o_take = i_user_en & ~i_master_dis & (|live); // see RQ2 see RQ5

    // registered one-hot pick of the lowest live request
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_ack_sel <= {N_IRQ{1'b0}};
        else if (o_take)
            o_ack_sel <= live & (~live + {{(N_IRQ-1){1'b0}}, 1'b1});
        else
            o_ack_sel <= {N_IRQ{1'b0}};
    end
endmodule
`default_nettype wire

// ---- rtl/irq_instr_unit.v ----
// Operation
// RQ1: opcode 8'h99 sets the user global enable bit, takes 4 cycles, keeps Z and S.
// RQ2: with the enable set, any unmasked request is acknowledged unless master-disabled.
// RQ3: opcode 8'h94 takes 4 cycles, keeps Z and S, then halts fetch until an interrupt.
// RQ4: while waiting, peripherals keep their clock; only the program is held.
// RQ5: opcode 8'h98 clears the enable bit; while clear, requests stay pending.
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctl_defs.vh"
module irq_instr_unit
#(
    parameter N_IRQ = 4
)
(
    // clock and reset
    input  wire             I_CLK,
    input  wire             I_RST_N,
    // instruction issue from the sequencer
    input  wire             i_DEC_VALID,
    input  wire [7:0]       i_OPCODE,
    // interrupt side, same clock domain
    input  wire [N_IRQ-1:0] i_IRQ_PEND,
    input  wire [N_IRQ-1:0] i_IRQ_MASK_N,
    input  wire             i_MASTER_DIS,
    // sequencer control
    output wire             o_BUSY,
    output reg              o_DONE,
    output wire             o_FETCH_HOLD,
    output wire             o_FLAG_KEEP,
    output wire             o_PERIPH_RUN,
    // interrupt acknowledge
    output wire             o_IRQ_TAKE,
    output wire [N_IRQ-1:0] o_IRQ_ACK,
    output wire             o_USER_EN
);
    // sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_WAIT = 2'h2;

    // state, counter and latched instruction kind
    reg [1:0] state_reg, state_next;
    reg [2:0] cnt_reg, cnt_next;
    reg       is_wait_reg, is_wait_next;
    // user enable bit and completion pulse
    reg       user_en_reg, user_en_next;
    reg       done_next;
    // issue accepted and acknowledge strobe
    wire      hit;
    wire      take;

    // opcode sets the user enable bit
    function is_enable_op;
        input [7:0] op;
        begin
            is_enable_op = (op == `OPC_USER_IRQ_ENABLE);
        end
    endfunction

    // opcode clears the user enable bit
    function is_disable_op;
        input [7:0] op;
        begin
            is_disable_op = (op == `OPC_USER_IRQ_DISABLE);
        end
    endfunction

    // opcode parks the program until a request
    function is_wait_op;
        input [7:0] op;
        begin
            is_wait_op = (op == `OPC_WAIT_FOR_IRQ);
        end
    endfunction

    // opcode is one this block executes
    function is_ours;
        input [7:0] op;
        begin
            is_ours = is_enable_op(op) || is_disable_op(op) || is_wait_op(op);
        end
    endfunction

    // last execute cycle of a handled instruction
    function exec_last;
        input [1:0] st;
        input [2:0] cnt;
        begin
            exec_last = (st == ST_EXEC) && (cnt == 3'h1);
        end
    endfunction

    // issue taken only from idle; other opcodes belong to the rest of the core
    assign hit = i_DEC_VALID && (state_reg == ST_IDLE) && is_ours(i_OPCODE);

    // sequencing state and execute cycle counter
    always @*
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (hit)
                begin
                    state_next = ST_EXEC;
                    cnt_next   = `INSTR_CYCLES - 3'h1; // see RQ1 see RQ3
                end
            end
            ST_EXEC:
            begin
                if (!exec_last(state_reg, cnt_reg))
                    cnt_next = cnt_reg - 3'h1;
                else if (is_wait_reg)
                    state_next = ST_WAIT; // see RQ3
                else
                    state_next = ST_IDLE;
            end
            ST_WAIT:
            begin
                if (|i_IRQ_PEND)
                    state_next = ST_IDLE; // see RQ3
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // remember whether the running instruction ends in a wait
    always @*
    begin
        is_wait_next = is_wait_reg;
        if (hit)
            is_wait_next = is_wait_op(i_OPCODE);
    end

    // user global enable bit, changed only at issue
    always @*
    begin
        user_en_next = user_en_reg;
        if (hit && is_enable_op(i_OPCODE))
            user_en_next = 1'b1; // see RQ1
        else if (hit && is_disable_op(i_OPCODE))
            user_en_next = 1'b0; // see RQ5
    end

    // one-cycle completion pulse after the last execute cycle
    always @*
    begin
        done_next = exec_last(state_reg, cnt_reg); // see RQ1 see RQ3
    end

    // state register
    always @(posedge I_CLK)
    begin
        if (!I_RST_N)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // execute cycle counter
    always @(posedge I_CLK)
    begin
        if (!I_RST_N)
            cnt_reg <= 3'h0;
        else
            cnt_reg <= cnt_next;
    end

    // latched wait kind
    always @(posedge I_CLK)
    begin
        if (!I_RST_N)
            is_wait_reg <= 1'b0;
        else
            is_wait_reg <= is_wait_next;
    end

    // user global enable bit
    always @(posedge I_CLK)
    begin
        if (!I_RST_N)
            user_en_reg <= `USER_IRQ_EN_RESET;
        else
            user_en_reg <= user_en_next;
    end

    // completion pulse register
    always @(posedge I_CLK)
    begin
        if (!I_RST_N)
            o_DONE <= 1'b0;
        else
            o_DONE <= done_next;
    end

    // issue and execution status to the sequencer
    assign o_BUSY       = (state_reg != ST_IDLE) || hit;
    assign o_FLAG_KEEP  = o_BUSY; // see RQ1 see RQ3

    // program parked; peripheral clocks never gated here
    assign o_FETCH_HOLD = (state_reg == ST_WAIT); // see RQ3
    assign o_PERIPH_RUN = 1'b1; // see RQ4

    // enable bit and acknowledge strobe out
    assign o_USER_EN    = user_en_reg;
    assign o_IRQ_TAKE   = take;

    // acknowledge gate
    irq_ack_gate #(
        .N_IRQ (N_IRQ)
    ) u_gate (
        .i_clk        (I_CLK),
        .i_rst_n      (I_RST_N),
        .i_pend       (i_IRQ_PEND),
        .i_mask_n     (i_IRQ_MASK_N),
        .i_user_en    (user_en_reg),
        .i_master_dis (i_MASTER_DIS),
        .o_take       (take),
        .o_ack_sel    (o_IRQ_ACK)
    );
endmodule
`default_nettype wire

// ---- tb/irq_instr_unit_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_instr_monitor #(parameter N_IRQ = 4)(
    input wire logic             I_CLK,
    input wire logic             I_RST_N,
    input wire logic [7:0]       i_OPCODE,
    input wire logic [N_IRQ-1:0] i_IRQ_PEND,
    input wire logic [N_IRQ-1:0] i_IRQ_MASK_N,
    input wire logic             i_MASTER_DIS,
    input wire logic             o_BUSY,
    input wire logic             o_DONE,
    input wire logic             o_FETCH_HOLD,
    input wire logic             o_PERIPH_RUN,
    input wire logic             o_IRQ_TAKE,
    input wire logic [N_IRQ-1:0] o_IRQ_ACK,
    input wire logic             o_USER_EN
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    a_enable_bit: assert property ($rose(o_BUSY) && i_OPCODE[7:1] == 7'h4c
        |=> o_USER_EN == $past(i_OPCODE[0])) else $error("enable bit wrong");
    a_exec_len: assert property ($rose(o_BUSY) && i_OPCODE != 8'h94
        |-> o_BUSY [*4] ##1 (o_DONE && !o_BUSY)) else $error("length wrong");
    a_wait_entry: assert property ($rose(o_BUSY) && i_OPCODE == 8'h94
        |-> !o_FETCH_HOLD [*4] ##1 o_FETCH_HOLD) else $error("wait entry wrong");
    a_wait_exit: assert property (o_FETCH_HOLD
        |=> o_FETCH_HOLD == !(|$past(i_IRQ_PEND))) else $error("wait exit wrong");
    a_take_gate: assert property (o_IRQ_TAKE ==
        (o_USER_EN && !i_MASTER_DIS && |(i_IRQ_PEND & i_IRQ_MASK_N))) else $error("take wrong");
    a_periph_run: assert property (o_PERIPH_RUN) else $error("peripheral run low");
    a_ack_onehot: assert property ($onehot0(o_IRQ_ACK)) else $error("ack not one-hot");
    cover property (o_FETCH_HOLD ##1 !o_FETCH_HOLD);
    cover property (o_IRQ_TAKE);
    cover property (o_DONE);
endmodule
bind irq_instr_unit irq_instr_monitor #(.N_IRQ(N_IRQ)) mon (
    .I_CLK        (I_CLK),
    .I_RST_N      (I_RST_N),
    .i_OPCODE     (i_OPCODE),
    .i_IRQ_PEND   (i_IRQ_PEND),
    .i_IRQ_MASK_N (i_IRQ_MASK_N),
    .i_MASTER_DIS (i_MASTER_DIS),
    .o_BUSY       (o_BUSY),
    .o_DONE       (o_DONE),
    .o_FETCH_HOLD (o_FETCH_HOLD),
    .o_PERIPH_RUN (o_PERIPH_RUN),
    .o_IRQ_TAKE   (o_IRQ_TAKE),
    .o_IRQ_ACK    (o_IRQ_ACK),
    .o_USER_EN    (o_USER_EN)
);
`default_nettype wire

// ---- tb/irq_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_src_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] raise,
    input  wire logic [3:0] ack,
    output var  logic [3:0] pend
);
    // sources follow raise each cycle, with any bit that is acknowledged cleared
    always @(posedge clk)
        pend <= rst_n ? raise & ~ack : 4'h0;
endmodule
`default_nettype wire

// ---- tb/test_global_irq_enable_and_wait.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_global_irq_enable_and_wait;
    logic       clk = 0, rst_n = 0, dv = 0, mdis = 0;
    logic [7:0] opc = 0, ops [4] = '{8'h99, 8'h98, 8'h94, 8'h5a};
    logic [3:0] mask = 0, raise = 0, m;
    wire  [3:0] pend, ack;
    wire        busy, done, hold, keep, run, take, ue;
    int         mismatches = 0, n_checks = 0, e = 0;
    always #10 clk = ~clk;
    irq_instr_unit uut (.I_CLK(clk), .I_RST_N(rst_n), .i_DEC_VALID(dv), .i_OPCODE(opc),
        .i_IRQ_PEND(pend), .i_IRQ_MASK_N(mask), .i_MASTER_DIS(mdis), .o_BUSY(busy),
        .o_DONE(done), .o_FETCH_HOLD(hold), .o_FLAG_KEEP(keep), .o_PERIPH_RUN(run),
        .o_IRQ_TAKE(take), .o_IRQ_ACK(ack), .o_USER_EN(ue));
    irq_src_model src (.clk(clk), .rst_n(rst_n), .raise(raise), .ack(ack), .pend(pend));
    task chk(input logic [3:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one instruction, then a request against the current enable
    task step(input logic [7:0] op);
        @(negedge clk);
        {mdis, mask} = 5'($urandom);
        dv = 1;
        opc = op;
        #1 chk(busy, op != 8'h5a);
        @(negedge clk);
        // a handled opcode keeps issuing new ones, which must be ignored
        dv = (op != 8'h5a);
        opc = ops[$urandom % 4];
        if (op[7:1] == 7'h4c)
            e = op[0];
        chk(ue, e);
        repeat (2) @(negedge clk);
        dv = 0;
        @(negedge clk);
        chk({keep, hold, done, run}, {{2{op == 8'h94}}, op != 8'h5a, 1'b1});
        chk(ue, e);
        if (op == 8'h94)
        begin
            repeat ($urandom % 8) @(negedge clk);
            raise = 4'($urandom) | 4'h1;
            @(negedge clk);
            chk(hold, 1);
            @(negedge clk);
            chk(hold, 0);
            raise = 0;
            repeat (2) @(negedge clk);
        end
        raise = 4'($urandom);
        m = raise & mask;
        @(negedge clk);
        chk(take, e && !mdis && m != 0);
        @(negedge clk);
        chk(ack, (e && !mdis) ? m & -m : 4'h0);
        raise = 0;
        repeat (2) @(negedge clk);
    endtask
    initial
    begin
        void'($urandom(32'h6bd66770));
        repeat (20) @(negedge clk);
        rst_n = 1;
        chk(ue, 0);
        for (int i = 0; i < 40; i++)
            step(ops[i < 4 ? i : $urandom % 4]);
        print_verdict;
    end
    // cut a hang short
    initial
    begin
        #200000;
        mismatches++;
        print_verdict;
    end
endmodule
`default_nettype wire
